// ==== hw/ims_core.sv ====
// ims_core: i2c master-status, arbitration-loss flag and communication reservation.
// assumes a plain register port on clk_i and scl/sda pins from outside (synchronised here);
// the shift engine sits outside, reports arbitration loss and takes the address-launch strobe.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ims_core
  import ims_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic [ims_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  input  wire logic                    bit_access_i,
  output logic      [7:0]              rdata_o,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_o,
  input  wire logic                    arb_lost_i,
  output logic                         addr_launch_o,
  output logic      [7:0]              addr_data_o,
  output logic                         irq_o
);
  import ims_pkg::*;

  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic       scl_q;
  logic       sda_q;
  logic       master;
  logic       arb_lost;
  logic       busy;
  logic       reserved;
  logic [7:0] ctrl0;
  logic [7:0] flag;
  logic [7:0] shift;
  logic       shift_valid;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [7:0] hold_cnt;
  ims_state_e state;
  ims_state_e next_state;

  // second synchroniser stage and its delayed copy feed edge detection
  wire scl_h    = scl_s[1];
  wire sda_h    = sda_s[1];
  wire start_ev = scl_h && scl_q && sda_q && !sda_h;
  wire stop_ev  = scl_h && scl_q && !sda_q && sda_h;

  wire sel_st   = (addr_i == REG_STATUS);
  wire sel_c0   = (addr_i == REG_CTRL0);
  wire sel_fl   = (addr_i == REG_FLAG);
  wire sel_sh   = (addr_i == REG_SHIFT);
  wire sel_is   = (addr_i == REG_IRQ_STAT);
  wire sel_im   = (addr_i == REG_IRQ_MASK);
  wire wr_c0    = wr_i && sel_c0;
  wire rd_st    = rd_i && sel_st;
  wire enable   = ctrl0[C0_ENABLE];
  wire en_fall  = wr_c0 && enable && !wdata_i[C0_ENABLE];
  wire release_w = wr_c0 && wdata_i[C0_RELEASE];
  wire start_req = wr_c0 && wdata_i[C0_START] && enable;
  wire rsv_ok   = !flag[FL_RSV_DIS];
  wire bus_free = !busy;
  wire go_now   = start_req && bus_free && (state == IMS_IDLE);
  wire go_rsv   = reserved && stop_ev && enable;
  wire gen_start = (state == IMS_START) && (hold_cnt == 8'h00);
  wire lose     = arb_lost_i && master;
  wire clr_ald  = rd_st || bit_access_i || en_fall;
  wire clr_mst  = stop_ev || lose || release_w || en_fall;
  wire [2:0] irq_set = {gen_start, lose, stop_ev && ctrl0[C0_STOP_IE]};

  wire [7:0] status_w = {master, arb_lost, 4'h0, busy, reserved};
  wire [7:0] rd_mux =
      sel_st ? status_w :
      sel_c0 ? ctrl0 :
      sel_fl ? flag :
      sel_sh ? shift :
      sel_is ? {5'h00, irq_stat} :
      sel_im ? {5'h00, irq_mask} : 8'h00;

  always_ff @(posedge clk_i) begin
    scl_s <= {scl_s[0], scl_i};
    sda_s <= {sda_s[0], sda_i};
    scl_q <= scl_h;
    sda_q <= sda_h;
  end

  always_comb begin
    next_state = state;
    case (state)
      IMS_IDLE:  if (go_now || go_rsv) next_state = IMS_START;
      IMS_START: if (gen_start) next_state = IMS_WAIT;
      IMS_WAIT:  if (clr_mst) next_state = IMS_IDLE;
      default:   next_state = IMS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state    <= IMS_IDLE;
      hold_cnt <= 8'h00;
    end else begin
      state    <= next_state;
      if (state != IMS_START) hold_cnt <= START_HOLD_CNT;
      else if (hold_cnt != 8'h00) hold_cnt <= hold_cnt - 8'h01;
    end
  end

  // flags: the set term wins over any clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      master   <= STATUS_RST[ST_MASTER];
      arb_lost <= STATUS_RST[ST_ARB_LOST];
      busy     <= STATUS_RST[ST_BUS_BUSY];
      reserved <= STATUS_RST[ST_RESERVED];
    end else begin
      if (gen_start) master <= 1'b1;
      else if (clr_mst) master <= 1'b0;
      if (lose) arb_lost <= 1'b1;
      else if (clr_ald) arb_lost <= 1'b0;
      if (start_ev || gen_start) busy <= 1'b1;
      else if (stop_ev || lose || release_w) busy <= 1'b0;
      if (start_req && !bus_free && rsv_ok) reserved <= 1'b1;
      else if (go_rsv || release_w || en_fall || !enable) reserved <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl0 <= CTRL0_RST;
      flag  <= FLAG_RST;
      shift <= SHIFT_RST;
      shift_valid <= 1'b0;
      irq_stat <= IRQ_RST;
      irq_mask <= IRQ_RST;
    end else begin
      if (wr_c0) ctrl0 <= {wdata_i[7], 1'b0, wdata_i[5:2], 1'b0, wdata_i[0]};
      if (wr_i && sel_fl) flag <= wdata_i;
      if (stop_ev) shift_valid <= 1'b0;
      if (wr_i && sel_sh) begin
        shift <= wdata_i;
        // only an address loaded in the start state, outside a stop cycle, may go out
        shift_valid <= (state == IMS_START) && !stop_ev;
      end else if (addr_launch_o) shift_valid <= 1'b0;
      if (wr_i && sel_im) irq_mask <= wdata_i[2:0];
      irq_stat <= irq_set | (irq_stat & ~((wr_i && sel_is) ? wdata_i[2:0] : 3'h0));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o       <= 8'h00;
      sda_o         <= 1'b0;
      sda_oe_o      <= 1'b0;
      addr_launch_o <= 1'b0;
      addr_data_o   <= 8'h00;
      irq_o         <= 1'b0;
    end else begin
      rdata_o       <= rd_i ? rd_mux : 8'h00;
      // sda stays pulled low through the wait state, so no false stop follows the start
      sda_oe_o      <= (next_state != IMS_IDLE);
      sda_o         <= 1'b0;
      addr_launch_o <= gen_start && shift_valid;
      addr_data_o   <= shift;
      irq_o         <= |((irq_set | irq_stat) & irq_mask);
    end
  end

  a_start_sets_mst: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gen_start |=> master) else $error("start did not set master flag");
  a_lose_flags: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lose |=> arb_lost && !master) else $error("arbitration loss flags wrong");
  a_stop_clrs_mst: assert property (@(posedge clk_i) disable iff (!nrst_i)
    stop_ev && !gen_start |=> !master) else $error("stop did not clear master");
  a_read_clrs_ald: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_st && !lose |=> !arb_lost) else $error("status read kept arb lost");
  a_bit_clrs_ald: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_access_i && !lose |=> !arb_lost) else $error("bit access kept arb lost");
  a_rsv_disabled: assert property (@(posedge clk_i) disable iff (!nrst_i)
    flag[FL_RSV_DIS] && !reserved |=> !reserved) else $error("reserved while disabled");
  a_free_starts: assert property (@(posedge clk_i) disable iff (!nrst_i)
    go_now |=> state == IMS_START ##[1:60] master) else $error("free bus start missing");
  a_busy_tracks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start_ev |=> busy) else $error("start did not mark busy");
  a_release_clr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    release_w && !gen_start |=> !master && !busy) else $error("release ignored");
  a_rsv_fires: assert property (@(posedge clk_i) disable iff (!nrst_i)
    go_rsv && state == IMS_IDLE |=> state == IMS_START) else $error("reservation idle");
  a_reset_zero: assert property (@(posedge clk_i)
    !nrst_i |=> status_w == STATUS_RST) else $error("status not cleared");


  // master flag and state machine agree
  a_master_state: assert property (@(posedge clk_i) disable iff (!nrst_i)
    master
    |-> state == IMS_WAIT)
    else $error("master flag outside wait state");
  a_idle_no_master: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == IMS_IDLE
    |-> !master)
    else $error("master flag set while idle");
  a_mst_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    master && !clr_mst
    |=> master)
    else $error("master flag dropped without cause");
  a_release_mst: assert property (@(posedge clk_i) disable iff (!nrst_i)
    release_w && !gen_start
    |=> !master)
    else $error("release kept master flag");
  a_enfall_mst: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_fall && !gen_start
    |=> !master)
    else $error("disable kept master flag");
  a_ctrl_selfclr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_c0
    |=> !ctrl0[C0_RELEASE] && !ctrl0[C0_START])
    else $error("trigger bits stored");

  // arbitration flag
  a_lose_irq: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lose
    |=> irq_stat[IRQ_ARB])
    else $error("arbitration loss not flagged in irq status");
  a_no_false_ald: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !lose && !arb_lost
    |=> !arb_lost)
    else $error("arb lost set without loss");
  a_enfall_ald: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_fall && !lose
    |=> !arb_lost)
    else $error("disable kept arb lost");
  a_ald_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    arb_lost && !clr_ald
    |=> arb_lost)
    else $error("arb lost dropped without cause");

  // start generation and wait state
  a_hold_drives: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gen_start
    |-> sda_oe_o)
    else $error("sda not pulled during start");
  a_oe_active: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sda_oe_o
    |-> state != IMS_IDLE)
    else $error("sda pulled while idle");
  a_wait_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == IMS_WAIT && !clr_mst
    |=> state == IMS_WAIT)
    else $error("wait state left without cause");
  a_start_busy: assert property (@(posedge clk_i) disable iff (!nrst_i)
    gen_start
    |=> busy)
    else $error("own start did not mark busy");

  // reservation
  a_rsv_taken: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start_req && !bus_free && rsv_ok
    |=> reserved)
    else $error("busy bus start not reserved");
  a_free_no_rsv: assert property (@(posedge clk_i) disable iff (!nrst_i)
    go_now && !reserved
    |=> !reserved)
    else $error("free bus start reserved");
  a_rsv_needs_en: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !enable
    |=> !reserved)
    else $error("reservation kept while disabled");
  a_rsv_used: assert property (@(posedge clk_i) disable iff (!nrst_i)
    go_rsv && !start_req
    |=> !reserved)
    else $error("reservation kept after stop");
  a_stop_irq: assert property (@(posedge clk_i) disable iff (!nrst_i)
    stop_ev && ctrl0[C0_STOP_IE]
    |=> irq_stat[IRQ_STOP])
    else $error("stop interrupt missing");
  a_stop_voids: assert property (@(posedge clk_i) disable iff (!nrst_i)
    stop_ev && !(wr_i && sel_sh)
    |=> !shift_valid)
    else $error("address before stop kept");
  a_launch_valid: assert property (@(posedge clk_i) disable iff (!nrst_i)
    addr_launch_o
    |-> $past(shift_valid) && $past(gen_start))
    else $error("launch without valid address");
  a_stop_frees: assert property (@(posedge clk_i) disable iff (!nrst_i)
    stop_ev && !start_ev && !gen_start
    |=> !busy)
    else $error("stop did not free bus");

  c_free_start: cover property (@(posedge clk_i) disable iff (!nrst_i) go_now);
  c_bit_clear: cover property (@(posedge clk_i) disable iff (!nrst_i) bit_access_i && arb_lost);
  c_reserve: cover property (@(posedge clk_i) disable iff (!nrst_i) go_rsv);
  c_arb_loss: cover property (@(posedge clk_i) disable iff (!nrst_i) lose);
  c_launch: cover property (@(posedge clk_i) disable iff (!nrst_i) addr_launch_o);
endmodule // ims_core
`default_nettype wire

// ==== hw/ims_pkg.sv ====
// ims_pkg: register map, field positions, reset values and timing constants
// for the i2c master-status and reservation block; no assumptions beyond 10 MHz clock.
package ims_pkg;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned ADDR_W         = 4;
  // register indices on the plain register port
  localparam logic [3:0] REG_STATUS      = 4'h0;
  localparam logic [3:0] REG_CTRL0       = 4'h1;
  localparam logic [3:0] REG_FLAG        = 4'h2;
  localparam logic [3:0] REG_SHIFT       = 4'h3;
  localparam logic [3:0] REG_IRQ_STAT    = 4'h4;
  localparam logic [3:0] REG_IRQ_MASK    = 4'h5;
  // bus_status_flags fields
  localparam int unsigned ST_MASTER      = 7;
  localparam int unsigned ST_ARB_LOST    = 6;
  localparam int unsigned ST_BUS_BUSY    = 1;
  localparam int unsigned ST_RESERVED    = 0;
  // bus_control_reg0 fields
  localparam int unsigned C0_ENABLE      = 7;
  localparam int unsigned C0_RELEASE     = 6;
  localparam int unsigned C0_STOP_IE     = 4;
  localparam int unsigned C0_START       = 1;
  // bus_flag_reg fields
  localparam int unsigned FL_RSV_DIS     = 0;
  // interrupt status fields
  localparam int unsigned IRQ_STOP       = 0;
  localparam int unsigned IRQ_ARB        = 1;
  localparam int unsigned IRQ_START      = 2;
  localparam logic [7:0] STATUS_RST      = 8'h00;
  localparam logic [7:0] CTRL0_RST       = 8'h00;
  localparam logic [7:0] FLAG_RST        = 8'h00;
  localparam logic [7:0] SHIFT_RST       = 8'h00;
  localparam logic [2:0] IRQ_RST         = 3'h0;
  // start hold: scl held high while sda falls, 4000 ns minimum
  localparam int unsigned START_HOLD_NS  = 4000;
  localparam int unsigned START_HOLD_CYC =
    (START_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] START_HOLD_CNT  = 8'(START_HOLD_CYC);
  typedef enum logic [1:0] {IMS_IDLE, IMS_START, IMS_WAIT} ims_state_e;
endpackage

// ==== verification/ims_bus_model.sv ====
// ims_bus_model: the other masters and slaves on the two-wire bus.
// Assumes open-drain lines with pull-ups. The block pulls sda low through sda_oe_i.
// scl runs at an 800 ns period only inside frames and stands still outside them.
`timescale 1ns/1ps
`default_nettype none
module ims_bus_model (
  input  wire logic sda_oe_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic drv;
  // wired-and of both parties, released lines float to the pull-up level
  assign sda_o = drv & ~(sda_oe_i & ~sda_i);
  initial begin
    scl_o = 1'b1;
    drv   = 1'b1;
  end
  task automatic bus_start();
    drv = 1'b0;
    #400 scl_o = 1'b0;
    repeat (4) begin
      #400 scl_o = 1'b1;
      #400 scl_o = 1'b0;
    end
  endtask
  task automatic bus_stop();
    scl_o = 1'b0;
    drv   = 1'b0;
    #400 scl_o = 1'b1;
    #400 drv = 1'b1;
  endtask
endmodule // ims_bus_model
`default_nettype wire

// ==== verification/testbench.sv ====
// testbench: self-checking bench for ims_core, 10 MHz clock.
// Assumes ims_bus_model plays the rest of the bus, and the assertions sit in the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ims_pkg::*;
  logic              clk_i, nrst_i, wr_i, rd_i, bit_access_i, arb_lost_i;
  logic [ADDR_W-1:0] addr_i;
  logic [7:0]        wdata_i, rdata_o, addr_data_o, rv;
  logic              scl, sda, sda_o, sda_oe_o, addr_launch_o, irq_o;
  int                error_cnt = 0;
  int                check_count = 0;
  typedef struct {logic [ADDR_W-1:0] a; logic [7:0] d; logic [7:0] e;} ims_row_s;
  ims_row_s rows[5] = '{'{REG_FLAG, 8'h01, 8'h01}, '{REG_FLAG, 8'h00, 8'h00},
    '{REG_SHIFT, 8'hA5, 8'hA5}, '{REG_IRQ_MASK, 8'h07, 8'h07}, '{4'hF, 8'h3C, 8'h00}};
  ims_core u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .bit_access_i(bit_access_i), .rdata_o(rdata_o),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .arb_lost_i(arb_lost_i),
    .addr_launch_o(addr_launch_o), .addr_data_o(addr_data_o), .irq_o(irq_o));
  ims_bus_model u_bus (.sda_oe_i(sda_oe_o), .sda_i(sda_o), .scl_o(scl), .sda_o(sda));
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, e);
  endtask
  // one-cycle pulse on arbitration loss (sel=1) or on a single-bit access (sel=0)
  task automatic pulse(input bit sel);
    @(posedge clk_i);
    if (sel) arb_lost_i <= 1'b1;
    else bit_access_i <= 1'b1;
    @(posedge clk_i);
    arb_lost_i   <= 1'b0;
    bit_access_i <= 1'b0;
  endtask
  // start on a free bus and wait until the start hold has passed
  task automatic go_master();
    reg_wr(REG_CTRL0, 8'h82);
    repeat (45) @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #2_000_000;
    error_cnt++;
    finish_test();
  end
  initial begin
    {nrst_i, wr_i, rd_i, bit_access_i, arb_lost_i, addr_i, wdata_i} = '0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(ADDR_W'(i), 8'h00);
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    reg_wr(REG_CTRL0, 8'h80);
    reg_wr(REG_CTRL0, 8'h82);
    repeat (2) @(posedge clk_i);
    #1 check({7'h00, sda_oe_o}, 8'h01);
    repeat (45) @(posedge clk_i);
    rd_chk(REG_STATUS, 8'h82);
    check({7'h00, irq_o}, 8'h01);
    rd_chk(REG_IRQ_STAT, 8'h04);
    reg_wr(REG_IRQ_STAT, 8'h04);
    repeat (2) @(posedge clk_i);
    check({7'h00, irq_o}, 8'h00);
    pulse(1'b1);
    rd_chk(REG_STATUS, 8'h40);
    rd_chk(REG_STATUS, 8'h00);
    go_master();
    pulse(1'b1);
    pulse(1'b0);
    rd_chk(REG_STATUS, 8'h00);
    go_master();
    pulse(1'b1);
    reg_wr(REG_CTRL0, 8'h00);
    rd_chk(REG_STATUS, 8'h00);
    u_bus.bus_stop();
    repeat (4) @(posedge clk_i);
    rd_chk(REG_STATUS, 8'h00);
    reg_wr(REG_CTRL0, 8'h80);
    reg_wr(REG_IRQ_STAT, 8'h07);
    u_bus.bus_start();
    reg_wr(REG_SHIFT, 8'h11);
    reg_wr(REG_CTRL0, 8'h92);
    rd_chk(REG_STATUS, 8'h03);
    reg_wr(REG_SHIFT, 8'h22);
    u_bus.bus_stop();
    repeat (4) @(posedge clk_i);
    reg_wr(REG_SHIFT, 8'h5A);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_i);
      #1;
      if (addr_launch_o === 1'b1) break;
    end
    check({7'h00, addr_launch_o}, 8'h01);
    check(addr_data_o, 8'h5A);
    rd_chk(REG_STATUS, 8'h82);
    rd_chk(REG_IRQ_STAT, 8'h05);
    reg_wr(REG_CTRL0, 8'hC0);
    rd_chk(REG_STATUS, 8'h00);
    reg_wr(REG_FLAG, 8'h01);
    u_bus.bus_start();
    reg_wr(REG_CTRL0, 8'h82);
    rd_chk(REG_STATUS, 8'h02);
    u_bus.bus_stop();
    repeat (60) @(posedge clk_i);
    rd_chk(REG_STATUS, 8'h00);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
